// >>> hw/vrcp_regs.svh
// Constants of the voice recorder command port controller.
// Assumes a 20 MHz clock and a byte-addressed Avalon-MM register map.
`ifndef VRCP_REGS_SVH
`define VRCP_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define VRCP_OFS_CMD 8'h00
`define VRCP_OFS_CFG 8'h04
`define VRCP_OFS_BWR 8'h08
`define VRCP_OFS_STAT 8'h0C
`define VRCP_BRD_TAG 3'h1

// ==========================================================
// Field positions
`define VRCP_CMD_ONLY_BIT 8
`define VRCP_CFG_RATE_LSB 0
`define VRCP_CFG_PART_LSB 2
`define VRCP_CFG_SLOT_LSB 4
`define VRCP_CFG_LAYOUT_BIT 7
`define VRCP_CFG_TRIG_LSB 8
`define VRCP_CFG_WIDTH_BIT 10
`define VRCP_CFG_RESET 11'h000
`define VRCP_STAT_CLR_BIT 1
`define VRCP_WORD_BUSY_BIT 0
`define VRCP_WORD_ACTIVE_BIT 1

// ==========================================================
// Command codes
`define VRCP_IDLE_CMD 4'h0
`define VRCP_PAUSE_CMD 4'h1
`define VRCP_PLAY_CMD 4'h2
`define VRCP_RECORD_MODE_CMD 4'h3
`define VRCP_START_CMD 4'h4
`define VRCP_STOP_CMD 4'h5
`define VRCP_RATE_SELECT_CMD 4'h6
`define VRCP_SLOT_SELECT_CMD 4'h7
`define VRCP_BOUNDS_WRITE_CMD 4'h8
`define VRCP_BOUNDS_READ_CMD 4'h9
`define VRCP_RAW_TRANSFER_CMD 4'hA
`define VRCP_EXTERNAL_STORE_CMD 4'hB
`define VRCP_TRIGGER_CONFIG_CMD 4'hC

// ==========================================================
// Timing
`define VRCP_CLK_NS 50
`define VRCP_T_CMD_NS 16000
`define VRCP_T_ADDR_NS 50000
`define VRCP_T_LONG_NS 270000
`define VRCP_T_BOOT_NS 125000
`define VRCP_T_SETTLE_NS 500000
`define VRCP_T_STB_NS 150

`endif

// >>> hw/vrcp_pkg.sv
// Types of the voice recorder command port controller.
// Assumes nothing beyond a SystemVerilog compiler.
package vrcp_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_POLL,
    ST_WRITE,
    ST_HOLD,
    ST_STEP,
    ST_READ,
    ST_WAIT
  } vrcp_state_t;

endpackage

// >>> hw/vrcp_nib_mem.sv
// Small memory that keeps the nibbles returned by a bounds read.
// Assumes one clock; read data come out of a register.
`timescale 1ns/1ns
module vrcp_nib_mem #(
  parameter int P_W = 4,
  parameter int P_D = 8,
  parameter int P_AW = 3
)(
  // Clock
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Write port
  input wire logic i_we,
  input wire logic [P_AW-1:0] i_waddr,
  input wire logic [P_W-1:0] i_wdata,
  // Read port
  input wire logic [P_AW-1:0] i_raddr,
  output logic [P_W-1:0] o_rdata
);
  logic [P_W-1:0] mem_reg [P_D];

  always_ff @(posedge i_clk)
  begin
    if (i_ce && i_we)
    begin
      mem_reg[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_rdata <= '0;
    end
    else if (i_ce)
    begin
      o_rdata <= mem_reg[i_raddr];
    end
  end
endmodule // vrcp_nib_mem

// >>> hw/vrcp_host.sv
// Host controller that drives the recorder over its 4-bit parallel port.
// Assumes an Avalon-MM master and a recorder bus synchronous to i_clk.
//
// What this block does
// - Command nibble codes zero through twelve
// - Rate select sends partition and rate nibble
// - Slot select sends layout flag and slot
// - Bounds write sends eight more nibbles
// - Bounds read takes eight read strobes
// - Trigger config sends width and level nibble
// - No command while busy bit high
// - While active only stop, pause, start or data-only nibbles
// - Bounds commands long busy, nibbles shorter
// - After external store, a timed wait replaces the busy poll before a command's first nibble
// - Strobes only while chip select low
`timescale 1ns/1ns
`include "vrcp_regs.svh"
module vrcp_host
  import vrcp_pkg::*;
#(
  parameter int P_LONG_CYC = 5400,
  parameter int P_BOOT_CYC = 12500
)(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Avalon-MM slave
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Recorder port
  input wire logic [3:0] i_dbus,
  output logic [3:0] o_dbus,
  output logic o_dbus_oe,
  output logic o_ce_n,
  output logic o_wr_n,
  output logic o_rd_n
);

  // ==========================================================
  // Helpers
  function automatic logic [15:0] cyc(input int ns);
    int c;
    c = (ns + `VRCP_CLK_NS - 1) / `VRCP_CLK_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[15:0];
  endfunction

  function automatic logic [3:0] nib_total(input logic [3:0] cmd,
                                           input logic only);
    if (only)
    begin
      return 4'h1;
    end
    case (cmd)
      `VRCP_BOUNDS_WRITE_CMD: return 4'h9;
      `VRCP_RATE_SELECT_CMD,
      `VRCP_SLOT_SELECT_CMD,
      `VRCP_TRIGGER_CONFIG_CMD: return 4'h2;
      default: return 4'h1;
    endcase
  endfunction

  function automatic logic [3:0] nib_of(input logic [3:0] cmd,
      input logic only, input logic [3:0] data, input logic [3:0] idx,
      input logic [10:0] cfg, input logic [31:0] bwr);
    logic [31:0] s;
    s = bwr >> {idx - 4'h1, 2'b00};
    if (only)
    begin
      return data;
    end
    if (idx == 4'h0)
    begin
      return cmd;
    end
    case (cmd)
      `VRCP_RATE_SELECT_CMD:
        return {cfg[`VRCP_CFG_PART_LSB+:2], cfg[`VRCP_CFG_RATE_LSB+:2]};
      `VRCP_SLOT_SELECT_CMD:
        return {cfg[`VRCP_CFG_LAYOUT_BIT], cfg[`VRCP_CFG_SLOT_LSB+:3]};
      `VRCP_TRIGGER_CONFIG_CMD:
        return {1'b0, cfg[`VRCP_CFG_WIDTH_BIT],
                cfg[`VRCP_CFG_TRIG_LSB+:2]};
      `VRCP_BOUNDS_WRITE_CMD: return s[3:0];
      default: return data;
    endcase
  endfunction

  localparam logic [15:0] CYC_STB = cyc(`VRCP_T_STB_NS);
  localparam logic [15:0] CYC_ADDR = cyc(`VRCP_T_ADDR_NS);
  localparam logic [15:0] CYC_LONG = 16'(P_LONG_CYC);
  localparam logic [15:0] CYC_BOOT = 16'(P_BOOT_CYC);

  // ==========================================================
  // Register bus
  logic [1:0] phase_reg, phase_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [10:0] cfg_reg, cfg_next;
  logic [31:0] bwr_reg, bwr_next;
  logic [3:0] mem_rdata;
  logic take_wr, go, clr_refused;

  vrcp_state_t state_reg, state_next, ret_reg, ret_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [3:0] idx_reg, idx_next;
  logic [3:0] cmd_reg, cmd_next, data_reg, data_next;
  logic only_reg, only_next;
  logic [3:0] word_reg, word_next;
  logic refused_reg, refused_next, stream_reg, stream_next;
  logic mem_we;
  logic [3:0] dbus_next;
  logic oe_next, ce_n_next, wr_n_next, rd_n_next;

  // Writes land only on the edge where waitrequest is low
  assign take_wr = (phase_reg == 2'h2) && i_write && i_byteenable[0];
  assign go = take_wr && (i_address == `VRCP_OFS_CMD);
  assign clr_refused = take_wr && (i_address == `VRCP_OFS_STAT) &&
                       i_writedata[`VRCP_STAT_CLR_BIT];

  always_comb
  begin
    phase_next = phase_reg;
    wait_next = wait_reg;
    rdata_next = rdata_reg;
    cfg_next = cfg_reg;
    bwr_next = bwr_reg;
    case (phase_reg)
      2'h0:
      begin
        if (i_read || i_write)
        begin
          phase_next = 2'h1;
        end
      end
      2'h1:
      begin
        // Extra cycle lets the nibble memory register its output
        phase_next = 2'h2;
        wait_next = 1'b0;
        rdata_next = 32'h0000_0000;
        if (i_address[7:5] == `VRCP_BRD_TAG && i_address[1:0] == 2'h0)
        begin
          rdata_next = {28'h000_0000, mem_rdata};
        end
        else
        begin
          case (i_address)
            `VRCP_OFS_CMD: rdata_next = {23'h00_0000, only_reg,
                                         data_reg, cmd_reg};
            `VRCP_OFS_CFG: rdata_next = {21'h00_0000, cfg_reg};
            `VRCP_OFS_BWR: rdata_next = bwr_reg;
            `VRCP_OFS_STAT: rdata_next = {24'h00_0000, word_reg, 1'b0,
                                          stream_reg, refused_reg,
                                          state_reg != ST_IDLE};
            default: rdata_next = 32'h0000_0000;
          endcase
        end
      end
      default:
      begin
        phase_next = 2'h0;
        wait_next = 1'b1;
        if (take_wr && i_address == `VRCP_OFS_CFG)
        begin
          cfg_next = i_writedata[10:0];
        end
        if (i_write && i_address == `VRCP_OFS_BWR)
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (i_byteenable[b])
            begin
              bwr_next[8*b+:8] = i_writedata[8*b+:8];
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      phase_reg <= 2'h0;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      cfg_reg <= `VRCP_CFG_RESET;
      bwr_reg <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      phase_reg <= phase_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      cfg_reg <= cfg_next;
      bwr_reg <= bwr_next;
    end
  end

  assign o_readdata = rdata_reg;
  assign o_waitrequest = wait_reg;

  // ==========================================================
  // Command sequencer
  always_comb
  begin
    state_next = state_reg;
    ret_next = ret_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    cmd_next = cmd_reg;
    data_next = data_reg;
    only_next = only_reg;
    word_next = word_reg;
    refused_next = refused_reg;
    stream_next = stream_reg;
    mem_we = 1'b0;
    if (clr_refused)
    begin
      refused_next = 1'b0;
    end
    case (state_reg)
      ST_BOOT:
      begin
        // Device stays busy after reset; status is not trusted yet
        if (cnt_reg == 16'h0000)
        begin
          state_next = ST_IDLE;
        end
        else
        begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      ST_IDLE:
      begin
        if (go)
        begin
          // Uses the status word seen at the last poll
          if (word_reg[`VRCP_WORD_ACTIVE_BIT] &&
              !i_writedata[`VRCP_CMD_ONLY_BIT] &&
              !(i_writedata[3:0] inside {`VRCP_STOP_CMD, `VRCP_PAUSE_CMD,
                                         `VRCP_START_CMD}))
          begin
            refused_next = 1'b1;
          end
          else
          begin
            cmd_next = i_writedata[3:0];
            data_next = i_writedata[7:4];
            only_next = i_writedata[`VRCP_CMD_ONLY_BIT];
            idx_next = 4'h0;
            cnt_next = CYC_STB - 16'h0001;
            state_next = stream_reg ? ST_WRITE : ST_POLL;
          end
        end
      end
      ST_POLL:
      begin
        if (cnt_reg == 16'h0000)
        begin
          word_next = i_dbus;
          cnt_next = CYC_STB - 16'h0001;
          if (i_dbus[`VRCP_WORD_BUSY_BIT])
          begin
            ret_next = ST_POLL;
            state_next = ST_WAIT;
          end
          else
          begin
            state_next = ST_WRITE;
          end
        end
        else
        begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      ST_WRITE:
      begin
        if (cnt_reg == 16'h0000)
        begin
          state_next = ST_HOLD;
        end
        else
        begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      ST_HOLD:
      begin
        state_next = ST_STEP;
      end
      ST_STEP:
      begin
        if (!only_reg && cmd_reg == `VRCP_BOUNDS_READ_CMD)
        begin
          // No busy bit here, so the host waits the full time
          idx_next = 4'h0;
          cnt_next = CYC_LONG - 16'h0001;
          ret_next = ST_READ;
          state_next = ST_WAIT;
        end
        else if (4'(idx_reg + 4'h1) < nib_total(cmd_reg, only_reg))
        begin
          idx_next = idx_reg + 4'h1;
          cnt_next = CYC_STB - 16'h0001;
          state_next = ST_POLL;
        end
        else
        begin
          if (!only_reg && cmd_reg == `VRCP_EXTERNAL_STORE_CMD)
          begin
            stream_next = 1'b1;
          end
          if (!only_reg && cmd_reg == `VRCP_STOP_CMD)
          begin
            stream_next = 1'b0;
          end
          if (stream_next)
          begin
            cnt_next = CYC_ADDR - 16'h0001;
            ret_next = ST_IDLE;
            state_next = ST_WAIT;
          end
          else
          begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_READ:
      begin
        if (cnt_reg == 16'h0000)
        begin
          mem_we = 1'b1;
          idx_next = idx_reg + 4'h1;
          cnt_next = CYC_ADDR - 16'h0001;
          ret_next = (idx_reg == 4'h7) ? ST_IDLE : ST_READ;
          state_next = ST_WAIT;
        end
        else
        begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      ST_WAIT:
      begin
        if (cnt_reg == 16'h0000)
        begin
          state_next = ret_reg;
          cnt_next = CYC_STB - 16'h0001;
        end
        else
        begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    // Orders while the sequencer works are dropped
    if (go && state_reg != ST_IDLE)
    begin
      refused_next = 1'b1;
    end
    // Pins follow the next state so each output is a flop
    ce_n_next = !(state_next inside {ST_POLL, ST_READ, ST_WRITE,
                                     ST_HOLD});
    rd_n_next = !(state_next inside {ST_POLL, ST_READ});
    wr_n_next = (state_next != ST_WRITE);
    oe_next = (state_next inside {ST_WRITE, ST_HOLD});
    dbus_next = o_dbus;
    if (state_next == ST_WRITE)
    begin
      dbus_next = nib_of(cmd_next, only_next, data_next, idx_next,
                         cfg_reg, bwr_reg);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      state_reg <= ST_BOOT;
      ret_reg <= ST_IDLE;
      cnt_reg <= CYC_BOOT - 16'h0001;
      idx_reg <= 4'h0;
      cmd_reg <= `VRCP_IDLE_CMD;
      data_reg <= 4'h0;
      only_reg <= 1'b0;
      word_reg <= 4'h0;
      refused_reg <= 1'b0;
      stream_reg <= 1'b0;
      o_dbus <= 4'h0;
      o_dbus_oe <= 1'b0;
      o_ce_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_rd_n <= 1'b1;
    end
    else if (i_ce)
    begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      cmd_reg <= cmd_next;
      data_reg <= data_next;
      only_reg <= only_next;
      word_reg <= word_next;
      refused_reg <= refused_next;
      stream_reg <= stream_next;
      o_dbus <= dbus_next;
      o_dbus_oe <= oe_next;
      o_ce_n <= ce_n_next;
      o_wr_n <= wr_n_next;
      o_rd_n <= rd_n_next;
    end
  end

  // ==========================================================
  // Bounds read store
  vrcp_nib_mem #(
    .P_W(4),
    .P_D(8),
    .P_AW(3)
  ) u_mem (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_we(mem_we),
    .i_waddr(idx_reg[2:0]),
    .i_wdata(i_dbus),
    .i_raddr(i_address[4:2]),
    .o_rdata(mem_rdata)
  );
endmodule // vrcp_host

// >>> bench/vrcp_dev_model.sv
// Behavioural recorder device on the 4-bit parallel port.
// Assumes the host strobes are levels sampled on the shared clock.
`timescale 1ns/1ns
module vrcp_dev_model #(
  parameter int P_BOOT = 30,
  parameter int P_CMD = 20,
  parameter int P_LONG = 18,
  parameter int P_ADDR = 900
)(
  // Port pins
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce_n,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic [3:0] i_dbus,
  output logic [3:0] o_dbus,
  // Observation
  output logic [7:0] o_log,
  output logic [7:0] o_cnt,
  output logic [10:0] o_par,
  output logic o_viol
);
  // =====
  // Device state
  int busy;
  int need;
  int rdi;
  logic act;
  logic pau;
  logic pwr;
  logic prd;
  logic [3:0] cmd;
  logic [3:0] last;
  logic [3:0] val;
  logic [3:0] mem [8];
  always_comb val = (rdi > 0) ? mem[8-rdi] :
                    {1'b0, pau, act, busy > 0};
  // Released bus shows no stale value
  assign o_dbus = (!i_ce_n && !i_rd_n) ? val : ~last;
  always @(posedge i_clk)
  begin
    pwr <= i_wr_n;
    prd <= i_rd_n;
    if (!i_ce_n && !i_rd_n)
      last <= val;
    if (!i_rstn)
    begin
      busy <= P_BOOT;
      need <= 0;
      rdi <= 0;
      act <= 1'b0;
      pau <= 1'b0;
      o_par <= 11'h000;
      o_log <= 8'h00;
      o_cnt <= 8'h00;
      o_viol <= 1'b0;
    end
    else
    begin
      if (busy > 0)
        busy <= busy - 1;
      if (i_rd_n && !prd && rdi > 0)
      begin
        if (busy > 0)
          o_viol <= 1'b1;
        rdi <= rdi - 1;
        busy <= P_ADDR;
      end
      if (i_wr_n && !pwr && !i_ce_n)
      begin
        if (busy > 0 || rdi > 0)
          o_viol <= 1'b1;
        else
        begin
          o_log <= {o_log[3:0], i_dbus};
          o_cnt <= o_cnt + 8'h01;
          if (need > 0)
          begin
            if (cmd == 4'h8)
              mem[8-need] <= i_dbus;
            if (cmd == 4'h6)
              o_par[3:0] <= i_dbus;
            if (cmd == 4'h7)
              o_par[7:4] <= i_dbus;
            if (cmd == 4'hC)
              o_par[10:8] <= i_dbus[2:0];
            need <= need - 1;
            busy <= (cmd == 4'h8) ? P_ADDR : P_CMD;
          end
          else
          begin
            cmd <= i_dbus;
            need <= (i_dbus inside {4'h6, 4'h7, 4'hC}) ? 1 :
              (i_dbus == 4'h8) ? 8 : 0;
            rdi <= (i_dbus == 4'h9) ? 8 : 0;
            busy <= (i_dbus[3:1] == 3'h4) ? P_LONG : P_CMD;
            if (i_dbus == 4'h4)
              act <= 1'b1;
            if (i_dbus == 4'h5)
              act <= 1'b0;
            if (i_dbus == 4'h1 && act)
              pau <= 1'b1;
            if (i_dbus inside {4'h4, 4'h5})
              pau <= 1'b0;
          end
        end
      end
    end
  end
endmodule // vrcp_dev_model

// >>> bench/vrcp_host_checker.sv
// Port checker for the recorder command port controller.
// Assumes it is bound to the controller and sees only its ports.
`timescale 1ns/1ns
module vrcp_host_checker (
  // Watched ports
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic o_waitrequest,
  input wire logic [3:0] i_dbus,
  input wire logic [3:0] o_dbus,
  input wire logic o_dbus_oe,
  input wire logic o_ce_n,
  input wire logic o_wr_n,
  input wire logic o_rd_n
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // =====
  // Recorder pins
  property p_wr_cs;
    !o_wr_n |-> !o_ce_n;
  endproperty
  a_wr_cs: assert property (p_wr_cs)
    else $error("write strobe outside chip select");
  property p_rd_float;
    !o_rd_n |-> !o_dbus_oe && o_wr_n;
  endproperty
  a_rd_float: assert property (p_rd_float)
    else $error("host drives bus during read");
  property p_wr_width;
    $fell(o_wr_n) |-> !o_wr_n[*3] ##1 (o_wr_n && !o_ce_n && o_dbus_oe);
  endproperty
  a_wr_width: assert property (p_wr_width)
    else $error("write strobe shape wrong");
  property p_wr_data;
    !o_wr_n |-> o_dbus_oe ##1 $stable(o_dbus);
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("nibble moved during write");
  property p_poll_first;
    $fell(o_wr_n) |-> $past(!o_rd_n) && !$past(i_dbus[0]);
  endproperty
  a_poll_first: assert property (p_poll_first)
    else $error("nibble written without idle status");
  property p_idle_pins;
    o_ce_n |-> o_wr_n && o_rd_n && !o_dbus_oe;
  endproperty
  a_idle_pins: assert property (p_idle_pins)
    else $error("strobe or drive without chip select");
  property p_rd_width;
    $fell(o_rd_n) |-> !o_rd_n[*3];
  endproperty
  a_rd_width: assert property (p_rd_width)
    else $error("read strobe too short");
  // =====
  // Register bus
  property p_ack;
    i_ce && o_waitrequest && ($rose(i_read) || $rose(i_write))
      |-> ##2 !o_waitrequest;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer late");
  property p_ack_one;
    !o_waitrequest |=> o_waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("waitrequest low too long");
endmodule // vrcp_host_checker

bind vrcp_host vrcp_host_checker u_vrcp_host_checker (
  .i_clk(i_clk),
  .i_rstn(i_rstn),
  .i_ce(i_ce),
  .i_read(i_read),
  .i_write(i_write),
  .o_waitrequest(o_waitrequest),
  .i_dbus(i_dbus),
  .o_dbus(o_dbus),
  .o_dbus_oe(o_dbus_oe),
  .o_ce_n(o_ce_n),
  .o_wr_n(o_wr_n),
  .o_rd_n(o_rd_n)
);

// >>> bench/tb_vrcp_host.sv
// Self-checking bench for the recorder command port controller.
// Assumes the behavioural device model and the bound checker.
`timescale 1ns/1ns
module tb_vrcp_host;
  localparam logic [31:0] bw_word = 32'hA5C31E79;
  logic clk, rstn, rd, wr, wreq, oe, ce_n, wr_n, rd_n, viol;
  logic [7:0] adr, lg, cnt;
  logic [31:0] wd, rdat, q;
  logic [3:0] hd, md;
  logic [10:0] par;
  int err_count, check_count;
  // Wire level: host drives only with its enable up
  wire [3:0] bus = oe ? hd : md;
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Small counts keep the run short
  vrcp_host #(.P_LONG_CYC(20), .P_BOOT_CYC(10)) u_vrcp_host (
    .i_clk(clk), .i_rstn(rstn), .i_ce(1'b1), .i_address(adr),
    .i_read(rd), .i_write(wr), .i_writedata(wd), .i_byteenable(4'hF),
    .o_readdata(rdat), .o_waitrequest(wreq), .i_dbus(bus), .o_dbus(hd),
    .o_dbus_oe(oe), .o_ce_n(ce_n), .o_wr_n(wr_n), .o_rd_n(rd_n));
  vrcp_dev_model u_vrcp_dev_model (
    .i_clk(clk), .i_rstn(rstn), .i_ce_n(ce_n), .i_wr_n(wr_n),
    .i_rd_n(rd_n), .i_dbus(bus), .o_dbus(md), .o_log(lg), .o_cnt(cnt),
    .o_par(par), .o_viol(viol));
  // =====
  // Shared tasks
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task bus_op(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    // Only the watchdog ends a wait that never gets its answer
    do
    begin
      @(posedge clk);
    end
    while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task idle;
    int n;
    n = 0;
    do
    begin
      bus_op(1'b0, 8'h0C, 32'h0);
      n++;
    end
    while (q[0] !== 1'b0 && n < 5000);
    chk("sequencer idle", q[0], 32'h0);
  endtask
  task cmd(input logic [31:0] c);
    bus_op(1'b1, 8'h00, c);
    idle;
  endtask
  // =====
  // Scenarios
  task t_boot;
    bus_op(1'b1, 8'h00, 32'h3);
    bus_op(1'b0, 8'h0C, 32'h0);
    chk("boot status", q[1:0], 32'h3);
    idle;
    chk("boot nibbles", cnt, 32'h0);
    bus_op(1'b1, 8'h0C, 32'h2);
    $display("t_boot done");
  endtask
  task t_single;
    for (int i = 0; i < 4; i++)
    begin
      cmd(i);
      chk("nibble", lg[3:0], i);
      chk("count", cnt, i + 1);
    end
    cmd(32'h4);
    cmd(32'h5);
    bus_op(1'b0, 8'h0C, 32'h0);
    chk("status word", q[7:4], 32'h2);
    chk("start stop", lg, 32'h45);
    cmd(32'h0);
    chk("active refusal", q[1], 32'h1);
    bus_op(1'b1, 8'h0C, 32'h2);
    cmd(32'h1);
    bus_op(1'b1, 8'h00, 32'h0);
    bus_op(1'b1, 8'h00, 32'h0);
    idle;
    chk("busy refusal", q[1], 32'h1);
    chk("one sent", cnt, 32'h8);
    bus_op(1'b1, 8'h0C, 32'h2);
    $display("t_single done");
  endtask
  task t_two;
    logic [7:0] e [3];
    e = '{8'h69, 8'h7B, 8'hC6};
    bus_op(1'b1, 8'h04, 32'h6B9);
    for (int i = 0; i < 3; i++)
    begin
      cmd({28'h0, e[i][7:4]});
      chk("pair", lg, e[i]);
    end
    chk("device params", par, 32'h6B9);
    cmd(32'h130);
    chk("data only", lg[3:0], 32'h3);
    $display("t_two done");
  endtask
  task t_bounds;
    bus_op(1'b1, 8'h08, bw_word);
    cmd(32'h8);
    chk("bounds tail", lg, 32'h5A);
    chk("bounds count", cnt, 32'h18);
    cmd(32'h9);
    for (int i = 0; i < 8; i++)
    begin
      bus_op(1'b0, 8'h20 + 8'(4 * i), 32'h0);
      chk("bounds nibble", q[3:0], bw_word[4*i +: 4]);
    end
    chk("device timing", viol, 32'h0);
    $display("t_bounds done");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #(50 * 40000);
    err_count++;
    end_sim;
  end
  initial
  begin
    rstn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0;
    err_count = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_boot;
    t_single;
    t_two;
    t_bounds;
    end_sim;
  end
endmodule // tb_vrcp_host
